// [verilog/ocs_clock_ctrl.sv]
// Clock source select, internal oscillator tuning and clock status.
// Assumes an AHB-Lite master as the only bus master, oscillator
// status levels from other domains, and per-source tick pulses
// already aligned to hclk.
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "ocs_consts.svh"

module ocs_clock_ctrl #(
	parameter int OLD_TICKS = `OCS_OLD_TICKS,
	parameter int NEW_TICKS = `OCS_NEW_TICKS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] fosc_config,
	input wire ocs_pkg::ocs_osc_status_t osc_status,
	input wire ocs_pkg::ocs_tick_t osc_tick,
	input wire logic sleep_exec,
	output ocs_pkg::ocs_osc_ctrl_t osc_ctrl,
	output ocs_pkg::ocs_src_t clk_sel,
	output logic clk_gate,
	output logic [15:0] int_freq_khz,
	output logic enter_idle,
	output logic enter_sleep,
	output logic wdt_clk_from_slow_rc
);
	import ocs_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// The pause counter is three bits wide
	if (OLD_TICKS < 1 || OLD_TICKS > 7) begin : g_bad_old
		$error("OLD_TICKS must lie in 1..7");
	end
	if (NEW_TICKS < 1 || NEW_TICKS > 7) begin : g_bad_new
		$error("NEW_TICKS must lie in 1..7");
	end

	localparam logic [2:0] OLD_LAST = 3'(OLD_TICKS - 1);
	localparam logic [2:0] NEW_LAST = 3'(NEW_TICKS - 1);

	// ****************************************
	// Functions
	// ****************************************
	// Clock select field to source
	function automatic ocs_src_t scs_decode(input logic [1:0] scs);
		ocs_src_t s;
		s = OCS_SRC_PRI;
		if (scs[1]) begin
			s = OCS_SRC_INT;
		end else if (scs[0]) begin
			s = OCS_SRC_SEC;
		end
		return s;
	endfunction

	// Tick of one source
	function automatic logic src_tick(input ocs_src_t s, input ocs_tick_t t);
		logic r;
		r = 1'b0;
		case (s)
			OCS_SRC_PRI: r = t.pri;
			OCS_SRC_SEC: r = t.sec;
			OCS_SRC_INT: r = t.intl;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// ****************************************
	// Register state
	// ****************************************
	logic lf_source_select;
	logic multiplier_enable;
	logic [4:0] freq_trim;
	logic idle_on_sleep;
	logic [2:0] internal_freq_select;
	logic [1:0] system_clock_select;
	logic secondary_osc_enable;
	logic primary_ready_flag;
	logic internal_stable_flag;
	logic secondary_running_flag;

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic dp_write;
	logic [`OCS_ADDR_W-1:0] dp_addr;
	wire addr_phase = hsel && hready && htrans[1];
	wire [`OCS_ADDR_W-1:0] ap_addr = haddr[`OCS_ADDR_W-1:0];
	wire hit_tune = dp_addr == `OCS_TUNE_OFS;
	wire hit_ctrl = dp_addr == `OCS_CTRL_OFS;
	wire hit_t1 = dp_addr == `OCS_T1_OFS;
	wire wr_tune = dp_write && hit_tune;
	wire wr_ctrl = dp_write && hit_ctrl;
	wire wr_t1 = dp_write && hit_t1;

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Capture the address phase of a write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= '0;
		end else begin
			dp_write <= addr_phase && hwrite;
			dp_addr <= ap_addr;
		end
	end

	// ****************************************
	// Multiplier gating
	// ****************************************
	wire cfg_internal = (fosc_config == `OCS_FOSC_INT_A) ||
		(fosc_config == `OCS_FOSC_INT_B);
	wire freq_ok = (internal_freq_select == `OCS_IFS_8M) ||
		(internal_freq_select == `OCS_IFS_4M);
	wire mult_allowed = cfg_internal && freq_ok;
	wire mult_eff = multiplier_enable && mult_allowed;
	wire [7:0] wtune = hwdata[7:0];
	// Writes are dropped and the bit falls back while not allowed
	wire next_mult_en = !mult_allowed ? 1'b0 :
		wr_tune ? wtune[`OCS_TUNE_MEN] : multiplier_enable;

	// ****************************************
	// Tuning register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lf_source_select <= 1'b0;
			freq_trim <= `OCS_TRIM_RST;
			multiplier_enable <= 1'b0;
		end else begin
			multiplier_enable <= next_mult_en;
			if (wr_tune) begin
				lf_source_select <= wtune[`OCS_TUNE_LFSS];
				freq_trim <= wtune[`OCS_TRIM_HI:0];
			end
		end
	end

	// ****************************************
	// Control and timer registers
	// ****************************************
	wire [7:0] wctrl = hwdata[7:0];
	wire [1:0] w_scs = wctrl[`OCS_SCS_HI:0];
	// A secondary request without its oscillator enabled is dropped
	wire scs_refused = (scs_decode(w_scs) == OCS_SRC_SEC) &&
		!secondary_osc_enable;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_on_sleep <= 1'b0;
			internal_freq_select <= `OCS_IFS_RST;
			system_clock_select <= `OCS_SCS_RST;
			secondary_osc_enable <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				idle_on_sleep <= wctrl[`OCS_CTRL_IDLE];
				internal_freq_select <= wctrl[`OCS_IFS_HI:`OCS_IFS_LO];
				if (!scs_refused) begin
					system_clock_select <= w_scs;
				end
			end
			if (wr_t1) begin
				secondary_osc_enable <= hwdata[`OCS_T1_OSCEN];
			end
		end
	end

	// ****************************************
	// Status synchroniser
	// ****************************************
	// Levels come from free-running oscillator domains
	ocs_osc_status_t st_meta;
	ocs_osc_status_t st_sync;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_meta <= '0;
			st_sync <= '0;
		end else begin
			st_meta <= osc_status;
			st_sync <= st_meta;
		end
	end

	// ****************************************
	// Glitch-free source switch
	// ****************************************
	ocs_sw_state_t sw_state;
	ocs_sw_state_t next_sw_state;
	ocs_src_t active_src;
	ocs_src_t next_active_src;
	logic [2:0] tick_cnt;
	logic [2:0] next_tick_cnt;
	wire ocs_src_t req_src = scs_decode(system_clock_select);
	wire cur_tick = src_tick(active_src, osc_tick);

	// Old source runs two cycles, then the new one three, clock held
	always_comb begin
		next_sw_state = sw_state;
		next_active_src = active_src;
		next_tick_cnt = tick_cnt;
		case (sw_state)
			OCS_RUN: begin
				if (req_src != active_src) begin
					next_sw_state = OCS_DRAIN;
					next_tick_cnt = 3'h0;
				end
			end
			OCS_DRAIN: begin
				if (cur_tick) begin
					next_tick_cnt = tick_cnt + 3'h1;
					if (tick_cnt == OLD_LAST) begin
						next_sw_state = OCS_FILL;
						next_active_src = req_src;
						next_tick_cnt = 3'h0;
					end
				end
			end
			OCS_FILL: begin
				if (cur_tick) begin
					next_tick_cnt = tick_cnt + 3'h1;
					if (tick_cnt == NEW_LAST) begin
						next_sw_state = OCS_RUN;
						next_tick_cnt = 3'h0;
					end
				end
			end
			default: begin
				next_sw_state = OCS_RUN;
				next_tick_cnt = 3'h0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_state <= OCS_RUN;
			active_src <= OCS_SRC_PRI;
			tick_cnt <= 3'h0;
		end else begin
			sw_state <= next_sw_state;
			active_src <= next_active_src;
			tick_cnt <= next_tick_cnt;
		end
	end

	// Device clock held while a switch is under way
	assign clk_gate = sw_state != OCS_RUN;
	assign clk_sel = active_src;

	// ****************************************
	// Oscillator controls
	// ****************************************
	wire slow_rc_low = (internal_freq_select == `OCS_IFS_31K) &&
		!lf_source_select;
	wire settled = sw_state == OCS_RUN;
	// Primary needs its multiplier lock when one is in use
	wire pll_needed = (fosc_config == `OCS_FOSC_XPLL) || mult_eff;
	wire next_prdy = settled && (active_src == OCS_SRC_PRI) &&
		st_sync.ost_done && (!pll_needed || st_sync.pll_lock);
	// Slow RC supply and an unsettled fast oscillator read as not stable
	wire next_istb = settled && (active_src == OCS_SRC_INT) &&
		!slow_rc_low && st_sync.fast_stable;
	wire next_secondary_running_flag = settled && (active_src == OCS_SRC_SEC) &&
		st_sync.sec_running;

	// Internal block frequency, nominal kHz
	wire [15:0] post_khz = `OCS_FAST_KHZ >> (3'h7 - internal_freq_select);
	wire [15:0] lf_khz = `OCS_LF_KHZ;
	wire [15:0] base_khz = (internal_freq_select == `OCS_IFS_31K) ? lf_khz : post_khz;
	wire [15:0] next_khz = mult_eff ? 16'(base_khz << `OCS_PLL_SHIFT) : base_khz;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_ctrl <= '0;
			int_freq_khz <= '0;
			primary_ready_flag <= 1'b0;
			internal_stable_flag <= 1'b0;
			secondary_running_flag <= 1'b0;
			wdt_clk_from_slow_rc <= 1'b0;
		end else begin
			osc_ctrl.fast_en <= !slow_rc_low;
			osc_ctrl.slow_en <= 1'b1;
			osc_ctrl.pll_en <= mult_eff;
			osc_ctrl.div256 <= lf_source_select;
			osc_ctrl.postscale <= internal_freq_select;
			osc_ctrl.trim <= freq_trim;
			int_freq_khz <= next_khz;
			// One source is active, so only one flag can rise
			primary_ready_flag <= next_prdy;
			internal_stable_flag <= next_istb;
			secondary_running_flag <= next_secondary_running_flag;
			wdt_clk_from_slow_rc <= 1'b1;
		end
	end

	// ****************************************
	// Sleep instruction
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enter_idle <= 1'b0;
			enter_sleep <= 1'b0;
		end else begin
			enter_idle <= sleep_exec && idle_on_sleep;
			enter_sleep <= sleep_exec && !idle_on_sleep;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Enable bit reads its effective value, so it reads zero when refused
	wire [7:0] rd_tune = {lf_source_select, mult_eff, 1'b0, freq_trim};
	wire [7:0] rd_ctrl = {idle_on_sleep, internal_freq_select,
		primary_ready_flag, internal_stable_flag, system_clock_select};
	wire [7:0] rd_t1 = {1'b0, secondary_running_flag, 2'b00,
		secondary_osc_enable, 3'b000};
	wire [7:0] rd_sel = (ap_addr == `OCS_TUNE_OFS) ? rd_tune :
		(ap_addr == `OCS_CTRL_OFS) ? rd_ctrl :
		(ap_addr == `OCS_T1_OFS) ? rd_t1 : 8'h00;

	// Sampled in the address phase, stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= {24'h000000, rd_sel};
		end
	end
endmodule

// [verilog/ocs_consts.svh]
// Constants of the clock select and oscillator control block.
// Included by the package and the design; definitions only.
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define OCS_ADDR_W 12
`define OCS_TUNE_OFS 12'h000
`define OCS_CTRL_OFS 12'h004
`define OCS_T1_OFS 12'h008

// ****************************************
// Field positions
// ****************************************
`define OCS_TUNE_LFSS 7
`define OCS_TUNE_MEN 6
`define OCS_TRIM_HI 4
`define OCS_CTRL_IDLE 7
`define OCS_IFS_HI 6
`define OCS_IFS_LO 4
`define OCS_CTRL_PRDY 3
`define OCS_CTRL_ISTB 2
`define OCS_SCS_HI 1
`define OCS_T1_RUN 6
`define OCS_T1_OSCEN 3

// ****************************************
// Reset values and codes
// ****************************************
`define OCS_TRIM_RST 5'h00
`define OCS_IFS_RST 3'h4
`define OCS_SCS_RST 2'h0
`define OCS_FOSC_INT_A 4'h9
`define OCS_FOSC_INT_B 4'h8
`define OCS_FOSC_XPLL 4'h6
`define OCS_IFS_8M 3'h7
`define OCS_IFS_4M 3'h6
`define OCS_IFS_31K 3'h0
`define OCS_FAST_KHZ 16'h1F40
`define OCS_LF_KHZ 16'h001F
`define OCS_PLL_SHIFT 2

// ****************************************
// Switch pause, in source cycles
// ****************************************
`define OCS_OLD_TICKS 2
`define OCS_NEW_TICKS 3

`endif

// [verilog/ocs_pkg.sv]
// Types shared by the clock select block and its bench.
// Assumes ocs_consts.svh is on the include path.
package ocs_pkg;
`include "ocs_consts.svh"

	// ****************************************
	// Clock sources and switch states
	// ****************************************
	typedef enum logic [1:0] {
		OCS_SRC_PRI = 2'b00,
		OCS_SRC_SEC = 2'b01,
		OCS_SRC_INT = 2'b10
	} ocs_src_t;

	typedef enum logic [1:0] {
		OCS_RUN = 2'b00,
		OCS_DRAIN = 2'b01,
		OCS_FILL = 2'b11
	} ocs_sw_state_t;

	// ****************************************
	// Oscillator status in, ticks in, control out
	// ****************************************
	typedef struct packed {
		logic ost_done;
		logic pll_lock;
		logic fast_stable;
		logic sec_running;
	} ocs_osc_status_t;

	typedef struct packed {
		logic pri;
		logic sec;
		logic intl;
	} ocs_tick_t;

	typedef struct packed {
		logic fast_en;
		logic slow_en;
		logic pll_en;
		logic div256;
		logic [2:0] postscale;
		logic [4:0] trim;
	} ocs_osc_ctrl_t;
endpackage

// [sim/ocs_clock_ctrl_monitor.sv]
// Checker for the clock select block, bound onto its ports.
// Assumes the design's ports only, its control and clock outputs included.
`timescale 1ns/100ps

module ocs_clock_ctrl_monitor #(
	parameter int OLD_TICKS = 2,
	parameter int NEW_TICKS = 3
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [3:0] fosc_config,
	input wire ocs_pkg::ocs_osc_status_t osc_status,
	input wire ocs_pkg::ocs_tick_t osc_tick,
	input wire logic sleep_exec,
	input wire ocs_pkg::ocs_osc_ctrl_t osc_ctrl,
	input wire ocs_pkg::ocs_src_t clk_sel,
	input wire logic clk_gate,
	input wire logic [15:0] int_freq_khz,
	input wire logic enter_idle,
	input wire logic enter_sleep,
	input wire logic wdt_clk_from_slow_rc
);
	import ocs_pkg::*;

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_PLL_FREQ: assert property (osc_ctrl.pll_en |-> osc_ctrl.postscale inside {3'h7, 3'h6})
		else $error("multiplier on outside 4 or 8 MHz");
	AST_PLL_CFG: assert property (osc_ctrl.pll_en |-> $past(fosc_config) inside {4'h9, 4'h8})
		else $error("multiplier on without internal config");
	AST_FAST_OFF: assert property ($past(hresetn) |->
		osc_ctrl.fast_en == !(osc_ctrl.postscale == 3'h0 && !osc_ctrl.div256))
		else $error("fast oscillator enable wrong");
	AST_WDT_SRC: assert property ($past(hresetn) |-> wdt_clk_from_slow_rc && osc_ctrl.slow_en)
		else $error("watchdog not on slow RC");
	AST_SLEEP: assert property (sleep_exec |=> enter_idle ^ enter_sleep)
		else $error("sleep pulse missing");
	AST_NO_SLEEP: assert property ((enter_idle || enter_sleep) |-> $past(sleep_exec))
		else $error("spurious sleep pulse");
	AST_SEL_CODE: assert property (clk_sel != 2'b11)
		else $error("bad clock source code");
	AST_GATE_SW: assert property ($changed(clk_sel) |-> clk_gate)
		else $error("source changed without pause");
	AST_GATE_END: assert property ($rose(clk_gate) |-> ##[1:300] !clk_gate)
		else $error("pause too long");
	// Nominal frequency tracks postscaler and multiplier together
	AST_FREQ: assert property ($past(hresetn) |-> int_freq_khz == ((osc_ctrl.postscale == 3'h0) ?
		16'd31 : (16'd8000 >> (3'h7 - osc_ctrl.postscale)) << (osc_ctrl.pll_en ? 2 : 0)))
		else $error("internal frequency wrong");

	COV_IDLE: cover property (enter_idle);
	COV_SW: cover property ($rose(clk_gate));
	COV_PLL: cover property (osc_ctrl.pll_en);
	COV_SEC: cover property (clk_sel == OCS_SRC_SEC && !clk_gate);
endmodule

bind ocs_clock_ctrl ocs_clock_ctrl_monitor #(.OLD_TICKS(OLD_TICKS), .NEW_TICKS(NEW_TICKS)) i_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .fosc_config(fosc_config), .osc_status(osc_status),
	.osc_tick(osc_tick), .sleep_exec(sleep_exec), .osc_ctrl(osc_ctrl), .clk_sel(clk_sel),
	.clk_gate(clk_gate), .int_freq_khz(int_freq_khz), .enter_idle(enter_idle),
	.enter_sleep(enter_sleep), .wdt_clk_from_slow_rc(wdt_clk_from_slow_rc));

// [sim/ocs_clock_ctrl_tb.sv]
// Self-checking bench for the clock select block.
// Assumes the bench is the only AHB master; ticks are random pulses.
`timescale 1ns/100ps

module ocs_clock_ctrl_tb;
	import ocs_pkg::*;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
	// ****************************************
	// Signals and model state
	// ****************************************
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_exec, clk_gate;
	logic enter_idle, enter_sleep, wdt_clk_from_slow_rc, m_pll;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] fosc_config;
	logic [15:0] int_freq_khz;
	logic [7:0] m_tune, m_ctrl, m_t1;
	ocs_osc_status_t osc_status;
	ocs_tick_t osc_tick;
	ocs_osc_ctrl_t osc_ctrl;
	ocs_src_t clk_sel;
	int err_count, samples_checked, seed;

	ocs_clock_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fosc_config(fosc_config),
		.osc_status(osc_status), .osc_tick(osc_tick), .sleep_exec(sleep_exec),
		.osc_ctrl(osc_ctrl), .clk_sel(clk_sel), .clk_gate(clk_gate),
		.int_freq_khz(int_freq_khz), .enter_idle(enter_idle), .enter_sleep(enter_sleep),
		.wdt_clk_from_slow_rc(wdt_clk_from_slow_rc));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Random source ticks keep the switch pause length varied
	always @(posedge hclk) begin
		osc_tick <= 3'($random(seed));
	end

	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			err_count++;
			give_verdict();
		end
	endtask

	// One AHB single transfer; read data taken at the data phase edge
	task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		wait_rdy();
		q = hrdata[7:0];
	endtask

	function automatic logic cond();
		return (fosc_config == 4'h9 || fosc_config == 4'h8) && m_ctrl[6:5] == 2'b11;
	endfunction

	function automatic logic [7:0] tune_exp();
		return {m_tune[7], m_pll, 1'b0, m_tune[4:0]};
	endfunction

	function automatic logic [15:0] freq(logic [2:0] c, logic p);
		return (c == 3'h0) ? 16'd31 : (16'd8000 >> (3'h7 - c)) << (p ? 2 : 0);
	endfunction

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(a, 1'b1, d, q);
		if (a == 12'h000) begin
			m_tune = d & 8'h9F;
			m_pll = d[6];
		end
		if (a == 12'h004)
			m_ctrl = {d[7:4], 2'b00, (d[1:0] == 2'b01 && !m_t1[3]) ? m_ctrl[1:0] : d[1:0]};
		if (a == 12'h008)
			m_t1 = d & 8'h08;
		m_pll = m_pll && cond();
	endtask

	task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input string nm);
		logic [7:0] q;
		bus(a, 1'b0, 8'h00, q);
		`CHK(nm, e, q)
		`CHK("hresp", 1'b0, hresp)
	endtask

	task automatic sw_wait(input ocs_src_t s);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (!(clk_sel === s && clk_gate === 1'b0) && n < 300);
		// A pause that never ends is a failure of its own
		if (clk_gate !== 1'b0) begin
			err_count++;
			give_verdict();
		end
		`CHK("clk_sel", s, clk_sel)
		repeat (5) @(posedge hclk);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 83355;
		{err_count, samples_checked} = 0;
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, fosc_config, osc_status, sleep_exec} = 0;
		{m_tune, m_t1, m_pll} = 0;
		hsize = 3'b010;
		m_ctrl = 8'h40;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd(12'h000, 8'h00, "tune_rst");
		chk_rd(12'h004, 8'h40, "ctrl_rst");
		chk_rd(12'h008, 8'h00, "t1_rst");
		chk_rd(12'h00C, 8'h00, "unmapped");
		`CHK("wdt", 1'b1, wdt_clk_from_slow_rc)
		// Multiplier bit refused while config is not internal
		for (int i = 0; i < 6; i++) begin
			wr(12'h000, 8'($random(seed)) | 8'h40);
			chk_rd(12'h000, tune_exp(), "tune");
			`CHK("trim", m_tune[4:0], osc_ctrl.trim)
		end
		// Clock found fast: trim stepped down through centre to below it
		for (int t = 1; t > -2; t--) begin
			wr(12'h000, 8'(t & 8'h1F));
			chk_rd(12'h000, tune_exp(), "trim_step");
			`CHK("trim_out", m_tune[4:0], osc_ctrl.trim)
		end
		osc_status <= 4'b1000;
		repeat (5) @(posedge hclk);
		chk_rd(12'h004, 8'h48, "pri_rdy");
		fosc_config <= 4'h9;
		wr(12'h004, 8'h70);
		wr(12'h000, 8'h40);
		chk_rd(12'h000, tune_exp(), "pll_on");
		`CHK("x4", 16'd32000, int_freq_khz)
		wr(12'h004, 8'h60);
		chk_rd(12'h000, tune_exp(), "pll_4m");
		`CHK("x4_4m", 16'd16000, int_freq_khz)
		wr(12'h004, 8'h50);
		wr(12'h004, 8'h70);
		chk_rd(12'h000, tune_exp(), "pll_drop");
		`CHK("pll_en", 1'b0, osc_ctrl.pll_en)
		// Every frequency code with both low-frequency sources
		for (int c = 0; c < 16; c++) begin
			wr(12'h000, {c[3], 7'h00});
			wr(12'h004, {1'b0, c[2:0], 4'h0});
			repeat (2) @(posedge hclk);
			`CHK("freq", freq(c[2:0], m_pll), int_freq_khz)
			`CHK("fast_en", !(c[2:0] == 3'h0 && !c[3]), osc_ctrl.fast_en)
			`CHK("div256", c[3], osc_ctrl.div256)
			`CHK("postscale", c[2:0], osc_ctrl.postscale)
		end
		wr(12'h004, 8'h71);
		chk_rd(12'h004, 8'h78, "sec_refused");
		wr(12'h008, 8'h08);
		// Secondary oscillator running and settled before it is selected
		osc_status <= 4'b0011;
		repeat (5) @(posedge hclk);
		wr(12'h004, 8'h71);
		sw_wait(OCS_SRC_SEC);
		chk_rd(12'h008, 8'h48, "sec_run");
		chk_rd(12'h004, 8'h71, "ctrl_sec");
		wr(12'h004, 8'h73);
		sw_wait(OCS_SRC_INT);
		chk_rd(12'h008, 8'h08, "t1_int");
		chk_rd(12'h004, 8'h77, "int_stb");
		wr(12'h000, 8'h00);
		wr(12'h004, 8'h02);
		repeat (5) @(posedge hclk);
		chk_rd(12'h004, 8'h02, "slow_rc");
		// Sleep instruction in both settings of the idle bit
		for (int k = 0; k < 2; k++) begin
			wr(12'h004, {k[0], 7'h02});
			sleep_exec <= 1'b1;
			@(posedge hclk);
			sleep_exec <= 1'b0;
			#1;
			`CHK("idle", k[0], enter_idle)
			`CHK("sleep", !k[0], enter_sleep)
			@(posedge hclk);
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd(12'h004, 8'h40, "ctrl_rerst");
		`CHK("clk_sel_rst", OCS_SRC_PRI, clk_sel)
		`CHK("freq_rst", 16'd1000, int_freq_khz)
		give_verdict();
	end
endmodule
